/* File: hw/afe_pkg.sv */
// Constants, field layout and types of the pixel formatter.
// Assumes one 50 MHz clock and a synchronous active-high reset.
// How it works
// RQ1 - Add black-level offset chosen by field.
// RQ2 - Invert gives full scale minus code.
// RQ3 - Format 0X: high bits, then low+flags.
// RQ4 - Format 10: seven bits plus flag twice.
// RQ5 - Format 11: four nibbles on upper pins.
// RQ6 - Colour flag high only for green.
// RQ7 - Over-range flag marks clipped inputs.
// RQ8 - Latency field delays output after sync.
// RQ9 - Host shifts address then data, MSB first.
// RQ10 - Input bits taken on serial clock rise.
// RQ11 - Load strobe writes shifted word to register.
// RQ12 - Write addresses keep bit four clear.
// RQ13 - Bit four set reads register back.
// RQ14 - Read-back bit changes on serial clock fall.
// RQ15 - Host holds output enable low for read-back.
// RQ16 - Next word shifts in during read-back.
// RQ17 - Correlated sampling bit resets to one.
// RQ18 - Gain and offset held per channel.
// RQ19 - Coefficients cycle or follow colour select.
// RQ20 - Cycle advances after the cycle pin rises.
// RQ21 - Host shifts exactly fourteen bits per word.
package afe_pkg;
  localparam logic [13:0] MAX_CODE = 14'h3fff; // Full scale.
  localparam logic [13:0] MID_CODE = 14'h1fff; // Mid scale.
  localparam logic [1:0] BL_FULL = 2'h2; // Offset by full scale.
  localparam logic [1:0] BL_NONE = 2'h3; // No offset.
  localparam logic [1:0] FMT_77 = 2'h2; // Seven plus seven.
  localparam logic [1:0] FMT_NIB = 2'h3; // Nibble format.
  localparam logic [1:0] CH_RED = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE = 2'h2;
  // Serial register addresses.
  localparam logic [5:0] ADDR_SETUP1 = 6'h01;
  localparam logic [5:0] ADDR_SETUP2 = 6'h02;
  localparam logic [5:0] ADDR_SETUP3 = 6'h03;
  localparam logic [5:0] ADDR_OFF_R = 6'h20; // Offsets at 0x20..0x22.
  localparam logic [5:0] ADDR_GAIN_R = 6'h28; // Gains at 0x28..0x2a.
  localparam int NREG = 9;
  localparam logic [3:0] IDX_SETUP1 = 4'h0;
  localparam logic [3:0] IDX_SETUP2 = 4'h1;
  localparam logic [3:0] IDX_SETUP3 = 4'h2;
  localparam logic [3:0] IDX_OFF = 4'h3; // Red, green, blue follow.
  localparam logic [3:0] IDX_GAIN = 4'h6;
  localparam logic [7:0] SETUP1_RST = 8'h02; // Correlated sampling on.
  localparam int A4_BIT = 4; // Read-back select bit of the address.
  // Field positions.
  localparam int F_CDS = 1;
  localparam int F_INV = 2;
  localparam int F_BL = 3; // Two bits.
  localparam int F_FMT = 5; // Two bits.
  localparam int F_LAT = 0; // Two bits, setup 2.
  localparam int F_ACYC = 2;
  localparam int F_FME = 3;
  localparam int F_CSEL = 4; // Two bits.
  localparam int F_LBL = 6;
  localparam int F_FM = 0; // Two bits, setup 3.
  // Bus side.
  localparam logic [11:0] APB_STATUS = 12'h100;
  localparam int LAT_BASE_CYC = 4; // Cycles added to the latency field.
  localparam int LAT_W = 4;
  typedef enum logic [1:0] {AFE_IDLE, AFE_WAIT, AFE_SEND} afe_fsm_t;
  // Maps a serial address to {valid, index}.
  function automatic logic [4:0] afe_reg_idx(input logic [5:0] a);
    case (a)
      ADDR_SETUP1: afe_reg_idx = {1'b1, IDX_SETUP1};
      ADDR_SETUP2: afe_reg_idx = {1'b1, IDX_SETUP2};
      ADDR_SETUP3: afe_reg_idx = {1'b1, IDX_SETUP3};
      ADDR_OFF_R, ADDR_OFF_R + 6'h1, ADDR_OFF_R + 6'h2:
        afe_reg_idx = {1'b1, IDX_OFF + {2'h0, a[1:0]}};
      ADDR_GAIN_R, ADDR_GAIN_R + 6'h1, ADDR_GAIN_R + 6'h2:
        afe_reg_idx = {1'b1, IDX_GAIN + {2'h0, a[1:0]}};
      default: afe_reg_idx = 5'h00;
    endcase
  endfunction : afe_reg_idx
endpackage : afe_pkg

/* File: hw/afe_ser_if.sv */
// Link between the serial control port and the register core.
// Assumes both ends run on the system clock.
`timescale 1ns/1ns
interface afe_ser_if;
  logic wr_stb; // One-cycle write pulse.
  logic [5:0] wr_addr; // Register address to write.
  logic [7:0] wr_data; // Data to write.
  logic [5:0] rd_addr; // Address whose contents are read back.
  logic [7:0] rd_data; // Contents at rd_addr.
  logic rd_active; // Read-back bits are on the serial output.
  logic ctrl_serial_out; // Current read-back bit.
  modport port(output wr_stb, wr_addr, wr_data, rd_addr, rd_active, ctrl_serial_out,
               input rd_data);
  modport core(input wr_stb, wr_addr, wr_data, rd_addr, rd_active, ctrl_serial_out,
               output rd_data);
endinterface : afe_ser_if

/* File: hw/afe_ser_port.sv */
// Three-wire serial control port: shift in, write or start read-back.
// Assumes pins from outside the clock domain; clock much faster than SCK.
`timescale 1ns/1ns
module afe_ser_port
  import afe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic load_strobe_i,
  afe_ser_if.port bus
);
  // Whole state of the port.
  typedef struct packed {
    logic [1:0] sck_s; // Serial clock synchroniser.
    logic sck_d; // Previous synchronised serial clock.
    logic [1:0] sdi_s; // Serial data synchroniser.
    logic [1:0] sen_s; // Load strobe synchroniser.
    logic sen_d;
    logic [13:0] sh; // Address and data shift register.
    logic [7:0] rd_sh; // Read-back shift register.
    logic [3:0] rd_cnt; // Read-back bits left.
    logic ctrl_serial_out;
    logic wr_stb;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
  } afe_ser_st_t;
  afe_ser_st_t st;
  afe_ser_st_t next_st;
  logic sck_rise;
  logic sck_fall;
  logic sen_rise;

  // Edges come from the second stage only.
  assign sck_rise = st.sck_s[1] & ~st.sck_d;
  assign sck_fall = ~st.sck_s[1] & st.sck_d;
  assign sen_rise = st.sen_s[1] & ~st.sen_d;
  assign bus.wr_stb = st.wr_stb;
  assign bus.wr_addr = st.wr_addr;
  assign bus.wr_data = st.wr_data;
  assign bus.rd_addr = {st.sh[13], 1'b0, st.sh[11:8]};
  assign bus.rd_active = (st.rd_cnt != 4'h0);
  assign bus.ctrl_serial_out = st.ctrl_serial_out;

  // Next state of the port.
  always_comb begin
    next_st = st;
    next_st.sck_s = {st.sck_s[0], sclk_i};
    next_st.sdi_s = {st.sdi_s[0], serial_in_i};
    next_st.sen_s = {st.sen_s[0], load_strobe_i};
    next_st.sck_d = st.sck_s[1];
    next_st.sen_d = st.sen_s[1];
    next_st.wr_stb = 1'b0;
    // Shifting goes on even while read-back runs. [RQ10] [RQ16]
    if (sck_rise) begin
      next_st.sh = {st.sh[12:0], st.sdi_s[1]};
    end
    // Read-back bits move on the falling serial clock. [RQ14]
    if (sck_fall && st.rd_cnt != 4'h0) begin
      next_st.rd_cnt = st.rd_cnt - 4'h1;
      next_st.ctrl_serial_out = st.rd_sh[6];
      next_st.rd_sh = {st.rd_sh[6:0], 1'b0};
    end
    if (sen_rise) begin
      if (st.sh[8 + A4_BIT]) begin
        // Read-back of the register with bit four cleared. [RQ13]
        next_st.rd_sh = bus.rd_data;
        next_st.ctrl_serial_out = bus.rd_data[7];
        next_st.rd_cnt = 4'h8;
      end else begin
        // Write of the shifted data word. [RQ11] [RQ12]
        next_st.wr_stb = 1'b1;
        next_st.wr_addr = st.sh[13:8];
        next_st.wr_data = st.sh[7:0];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_shift_in;
    @(posedge clk_i) disable iff (rst_i)
    sck_rise |=> st.sh[0] == $past(st.sdi_s[1]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not taken"); // [RQ10]
  property p_write;
    @(posedge clk_i) disable iff (rst_i)
    sen_rise && !st.sh[12] |=> st.wr_stb && st.wr_data == $past(st.sh[7:0]);
  endproperty
  a_write: assert property (p_write) else $error("write lost"); // [RQ11]
  property p_no_wr_a4;
    @(posedge clk_i) disable iff (rst_i)
    sen_rise && st.sh[12] |=> !st.wr_stb;
  endproperty
  a_no_wr_a4: assert property (p_no_wr_a4) else $error("read wrote"); // [RQ12]
  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
    sen_rise && st.sh[12] |=> bus.rd_active && st.ctrl_serial_out == $past(bus.rd_data[7]);
  endproperty
  a_readback: assert property (p_readback) else $error("no read-back"); // [RQ13]
  property p_sdo_fall;
    @(posedge clk_i) disable iff (rst_i)
    $changed(st.ctrl_serial_out) |-> $past(sck_fall || sen_rise);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved"); // [RQ14]
  property p_shift_rd;
    @(posedge clk_i) disable iff (rst_i)
    bus.rd_active && sck_rise |=> st.sh[13:1] == $past(st.sh[12:0]);
  endproperty
  a_shift_rd: assert property (p_shift_rd) else $error("input stalled"); // [RQ16]
endmodule : afe_ser_port

/* File: hw/afe_fmt_top.sv */
// Output formatter, register file and colour cycling of the front end.
// Assumes conversion inputs are stable in the clock domain around each
// pixel sync; sync, enable and cycle pins are asynchronous.
`timescale 1ns/1ns
module afe_fmt_top
  import afe_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic signed [14:0] CONV_CODE_I,
  input wire logic CONV_OVR_I,
  input wire logic [1:0] CONV_CHAN_I,
  input wire logic PIXEL_SYNC_I,
  input wire logic CLAMP_OR_CYCLE_PIN_I,
  input wire logic OUTPUT_ENABLE_N_I,
  output logic [7:0] PIXEL_OUT_BUS_O,
  output logic PIXEL_OUT_OE_O,
  output logic PIXEL_VALID_O,
  input wire logic CTRL_SCLK_I,
  input wire logic CTRL_SERIAL_IN_I,
  input wire logic CTRL_LOAD_STROBE_I,
  output logic CORR_SAMPLE_EN_O,
  output logic [23:0] GAIN_CODE_O,
  output logic [23:0] OFFSET_CODE_O,
  output logic [1:0] COEF_SEL_O,
  output logic [1:0] INPUT_MUX_O
);

  // Whole state of the core.
  typedef struct packed {
    logic [1:0] sync_s; // Pixel sync synchroniser.
    logic sync_d;
    logic [1:0] oen_s; // Output enable synchroniser.
    logic [1:0] cyc_s; // Auto-cycle pin synchroniser.
    logic cyc_d;
    logic [NREG-1:0][7:0] cfg; // Register file.
    afe_fsm_t fsm;
    logic [LAT_W-1:0] lat; // Latency countdown.
    logic [1:0] widx; // Word being shown.
    logic [1:0] fmt; // Format held for the pixel.
    logic [13:0] dcode; // Offset and polarity applied code.
    logic cc;
    logic ov;
    logic out_valid;
    logic [7:0] pins; // Pixel word.
    logic p7; // Top pin, shared with read-back.
    logic oe;
    logic [1:0] cyc; // Auto-cycle colour.
    logic [1:0] coef;
    logic [1:0] mux;
    logic [31:0] prdata;
    logic pslverr;
  } afe_core_st_t;

  afe_core_st_t st;
  afe_core_st_t next_st;
  afe_ser_if bus ();
  logic cap; // Pixel sync edge.
  logic cyc_rise;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [1:0] csel;
  logic signed [16:0] sum;
  logic [13:0] off;
  logic [13:0] clip;
  logic clip_ov;
  logic [4:0] ridx;
  logic [4:0] wr_idx; // Register index of the pending serial write.
  logic [4:0] aidx;
  logic amap;
  logic [7:0] wd;

  // Serial control port.
  afe_ser_port u_ser (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .sclk_i(CTRL_SCLK_I),
    .serial_in_i(CTRL_SERIAL_IN_I),
    .load_strobe_i(CTRL_LOAD_STROBE_I),
    .bus(bus.port)
  );

  // Builds word idx of the pixel in the held format.
  function automatic logic [7:0] afe_word(input logic [1:0] f, input logic [1:0] i,
                                          input logic [13:0] d, input logic c,
                                          input logic o);
    if (f == FMT_NIB) begin
      case (i)
        2'h0: afe_word = {d[13:10], 4'h0}; // [RQ5]
        2'h1: afe_word = {d[9:6], 4'h0};
        2'h2: afe_word = {d[5:2], 4'h0};
        default: afe_word = {d[1:0], c, o, 4'h0};
      endcase
    end else if (f == FMT_77) begin
      afe_word = (i == 2'h0) ? {d[13:7], c} : {d[6:0], o}; // [RQ4]
    end else begin
      afe_word = (i == 2'h0) ? d[13:6] : {d[5:0], c, o}; // [RQ3]
    end
  endfunction : afe_word

  assign s1 = st.cfg[IDX_SETUP1];
  assign s2 = st.cfg[IDX_SETUP2];
  assign cap = st.sync_s[1] & ~st.sync_d;
  assign cyc_rise = st.cyc_s[1] & ~st.cyc_d;
  assign csel = (s2[F_CSEL +: 2] == CH_BLUE) ? CH_BLUE : {1'b0, s2[F_CSEL]};
  assign ridx = afe_reg_idx(bus.rd_addr);
  assign wr_idx = afe_reg_idx(bus.wr_addr);
  assign bus.rd_data = ridx[4] ? st.cfg[ridx[3:0]] : 8'h00;
  assign aidx = afe_reg_idx(PADDR_I[7:2]);
  assign amap = (PADDR_I[11:8] == 4'h0) && (PADDR_I[1:0] == 2'h0) && aidx[4];

  // Black-level offset, clip and polarity of the incoming code.
  always_comb begin
    case (s1[F_BL +: 2])
      BL_NONE: off = 14'h0000; // [RQ1]
      BL_FULL: off = MAX_CODE;
      default: off = MID_CODE;
    endcase
    sum = 17'(CONV_CODE_I) + $signed({3'h0, off});
    clip_ov = 1'b0;
    if (sum < 0) begin
      clip = 14'h0000;
      clip_ov = 1'b1;
    end else if (sum > $signed({3'h0, MAX_CODE})) begin
      clip = MAX_CODE;
      clip_ov = 1'b1;
    end else begin
      clip = sum[13:0];
    end
    if (s1[F_INV]) begin
      clip = MAX_CODE - clip; // [RQ2]
    end
  end

  // Next state of the core.
  always_comb begin
    next_st = st;
    next_st.sync_s = {st.sync_s[0], PIXEL_SYNC_I};
    next_st.oen_s = {st.oen_s[0], OUTPUT_ENABLE_N_I};
    next_st.cyc_s = {st.cyc_s[0], CLAMP_OR_CYCLE_PIN_I};
    next_st.sync_d = st.sync_s[1];
    next_st.cyc_d = st.cyc_s[1];
    next_st.oe = ~st.oen_s[1];
    wd = st.pins;
    // Pixel pipeline: capture, wait the latency, then send words.
    case (st.fsm)
      AFE_IDLE: begin
        next_st.out_valid = 1'b0;
      end
      AFE_WAIT: begin
        if (st.lat == '0) begin
          next_st.fsm = AFE_SEND;
          next_st.widx = 2'h0;
          next_st.out_valid = 1'b1;
          wd = afe_word(st.fmt, 2'h0, st.dcode, st.cc, st.ov);
        end else begin
          next_st.lat = st.lat - LAT_W'(1);
        end
      end
      AFE_SEND: begin
        if (st.widx == ((st.fmt == FMT_NIB) ? 2'h3 : 2'h1)) begin
          next_st.fsm = AFE_IDLE;
          next_st.out_valid = 1'b0;
        end else begin
          next_st.widx = st.widx + 2'h1;
          wd = afe_word(st.fmt, st.widx + 2'h1, st.dcode, st.cc, st.ov);
        end
      end
      default: begin
        next_st.fsm = AFE_IDLE;
      end
    endcase
    // A new sync edge takes the conversion and restarts the count.
    if (cap) begin
      next_st.fsm = AFE_WAIT;
      next_st.out_valid = 1'b0;
      next_st.lat = LAT_W'(LAT_BASE_CYC) + LAT_W'(s2[F_LAT +: 2]); // [RQ8]
      next_st.dcode = clip; // [RQ1] [RQ2]
      next_st.fmt = s1[F_FMT +: 2];
      next_st.cc = (CONV_CHAN_I == CH_GREEN); // [RQ6]
      next_st.ov = CONV_OVR_I | clip_ov; // [RQ7]
    end
    next_st.pins = wd;
    // Read-back owns the top pin while it runs.
    next_st.p7 = bus.rd_active ? bus.ctrl_serial_out : wd[7]; // [RQ15]
    // Colour cycling in line-by-line mode. [RQ19] [RQ20]
    if (cyc_rise && s2[F_LBL] && s2[F_ACYC]) begin
      next_st.cyc = (st.cyc == CH_BLUE) ? CH_RED : st.cyc + 2'h1;
    end
    next_st.coef = (s2[F_LBL] && s2[F_ACYC]) ? st.cyc : csel; // [RQ19]
    next_st.mux = s2[F_FME] ? st.cfg[IDX_SETUP3][F_FM +: 2] : next_st.coef;
    // Bus read data and error are set up in the setup phase.
    if (PSEL_I && !PENABLE_I) begin
      next_st.pslverr = 1'b0;
      if (amap) begin
        next_st.prdata = {24'h0, st.cfg[aidx[3:0]]};
      end else if (PADDR_I == APB_STATUS) begin
        next_st.prdata = {24'h0, bus.rd_active, st.out_valid, st.fsm == AFE_WAIT,
                          st.cyc, st.cc, st.ov, st.oe};
      end else begin
        next_st.prdata = 32'h0;
        next_st.pslverr = 1'b1;
      end
    end
    // Bus write in the access phase, then a serial write on top. [RQ18]
    if (PSEL_I && PENABLE_I && PWRITE_I && amap) begin
      next_st.cfg[aidx[3:0]] = PWDATA_I[7:0];
    end
    if (bus.wr_stb && wr_idx[4] && !bus.wr_addr[A4_BIT]) begin
      next_st.cfg[wr_idx[3:0]] = bus.wr_data; // [RQ11] [RQ12]
    end
  end

  // State register.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      st.cfg[IDX_SETUP1] <= SETUP1_RST; // [RQ17]
    end else begin
      st <= next_st;
    end
  end

  assign PREADY_O = 1'b1;
  assign PRDATA_O = st.prdata;
  assign PSLVERR_O = st.pslverr;
  assign PIXEL_OUT_BUS_O = {st.p7, st.pins[6:0]};
  assign PIXEL_OUT_OE_O = st.oe;
  assign PIXEL_VALID_O = st.out_valid;
  assign CORR_SAMPLE_EN_O = s1[F_CDS]; // [RQ17]
  assign GAIN_CODE_O = {st.cfg[IDX_GAIN + 4'h2], st.cfg[IDX_GAIN + 4'h1], st.cfg[IDX_GAIN]};
  assign OFFSET_CODE_O = {st.cfg[IDX_OFF + 4'h2], st.cfg[IDX_OFF + 4'h1], st.cfg[IDX_OFF]};
  assign COEF_SEL_O = st.coef;
  assign INPUT_MUX_O = st.mux;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_no_offset;
    cap && s1[F_BL +: 2] == BL_NONE && !s1[F_INV] && CONV_CODE_I >= 0 |=>
      st.dcode == $past(CONV_CODE_I[13:0]);
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("offset wrong"); // [RQ1]
  property p_mid;
    cap && s1[F_BL +: 2] == 2'h0 && !s1[F_INV] && CONV_CODE_I == 0 |=> st.dcode == MID_CODE;
  endproperty
  a_mid: assert property (p_mid) else $error("mid scale wrong"); // [RQ1]
  property p_invert;
    cap && s1[F_BL +: 2] == BL_NONE && s1[F_INV] && CONV_CODE_I >= 0 |=>
      st.dcode == MAX_CODE - $past(CONV_CODE_I[13:0]);
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong"); // [RQ2]
  property p_fmt86;
    st.out_valid && !st.fmt[1] && st.widx == 2'h1 |-> st.pins[1:0] == {st.cc, st.ov};
  endproperty
  a_fmt86: assert property (p_fmt86) else $error("8+6 flags wrong"); // [RQ3]
  property p_fmt77;
    st.out_valid && st.fmt == FMT_77 |-> st.pins[0] == (st.widx == 2'h0 ? st.cc : st.ov);
  endproperty
  a_fmt77: assert property (p_fmt77) else $error("7+7 flag wrong"); // [RQ4]
  property p_nib;
    st.out_valid && st.fmt == FMT_NIB |-> st.pins[3:0] == 4'h0;
  endproperty
  a_nib: assert property (p_nib) else $error("low pins driven"); // [RQ5]
  property p_cc;
    cap |=> st.cc == ($past(CONV_CHAN_I) == CH_GREEN);
  endproperty
  a_cc: assert property (p_cc) else $error("colour flag wrong"); // [RQ6]
  property p_ov;
    cap && CONV_OVR_I |=> st.ov;
  endproperty
  a_ov: assert property (p_ov) else $error("over-range lost"); // [RQ7]
  sequence s_cap0;
    cap && s2[F_LAT +: 2] == 2'h0;
  endsequence
  sequence s_first;
    st.out_valid && st.widx == 2'h0;
  endsequence
  property p_latency;
    // Field zero: four cycles of base wait, one to load, one to show.
    s_cap0 ##1 !cap [*6] |-> s_first;
  endproperty
  a_latency: assert property (p_latency) else $error("latency wrong"); // [RQ8]
  property p_cds_rst;
    $fell(SYS_RST_I) |-> CORR_SAMPLE_EN_O;
  endproperty
  a_cds_rst: assert property (p_cds_rst) else $error("cds reset wrong"); // [RQ17]
  property p_gain;
    bus.wr_stb && bus.wr_addr == ADDR_GAIN_R + 6'h1 |=> GAIN_CODE_O[15:8] == $past(bus.wr_data);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not stored"); // [RQ18]
  property p_cycle;
    cyc_rise && s2[F_LBL] && s2[F_ACYC] |=>
      st.cyc == (($past(st.cyc) == CH_BLUE) ? CH_RED : $past(st.cyc) + 2'h1);
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle step wrong"); // [RQ20]
endmodule : afe_fmt_top

/* File: verif/afe_host_model.sv */
// Scanner-controller model that drives the three-wire control port.
// Assumes the device samples the serial pins with its own faster clock.
`timescale 1ns/1ns
module afe_host_model (
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic sen_o,
  output logic oe_n_o
);
  logic [7:0] rd_bits; // Read-back bits seen during the last word.

  // Serial clock stands low between words, and the output enable stays low.
  initial begin
    {sclk_o, sdi_o, sen_o, oe_n_o} = 4'h0;
    rd_bits = 8'h00;
  end

  // Shifts one word MSB first, sampling the read-back pin before each of the first eight falls.
  task automatic send(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      sdi_o = w[i];
      #80 sclk_o = 1'b1;
      #79 if (i >= 6) rd_bits[i - 6] = sdo_i;
      #1 sclk_o = 1'b0;
    end
    sdi_o = ~w[0]; // A released line does not keep its last bit.
    #80 sen_o = 1'b1;
    #80 sen_o = 1'b0;
    #200;
  endtask : send
endmodule : afe_host_model

/* File: verif/tb_afe_output_format_and_serial_ctrl.sv */
// Self-checking bench for the pixel formatter, its APB registers and serial port.
// Assumes the host model drives the serial pins and the bench drives APB and pixels.
`timescale 1ns/1ns
module tb_afe_output_format_and_serial_ctrl;
  import afe_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, got;
  logic pready, pslverr, rerr, ovr = 1'b0, sync = 1'b0, cyc = 1'b0;
  logic signed [14:0] code = 15'sd0;
  logic [1:0] chan = 2'h0, csel, imux;
  logic [7:0] pout;
  logic poe, pvalid, sclk, ctrl_serial_in, ctrl_load_strobe, oe_n, cse;
  logic [23:0] gain, offs;
  logic [3:0] kk;
  logic signed [14:0] codes [4] = '{15'sd3000, -15'sd1000, 15'sd5000, 15'sd9000};
  int errors = 0, n_checks = 0, lat, l0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  afe_fmt_top u_afe_fmt_top (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CONV_CODE_I(code),
    .CONV_OVR_I(ovr), .CONV_CHAN_I(chan), .PIXEL_SYNC_I(sync),
    .CLAMP_OR_CYCLE_PIN_I(cyc), .OUTPUT_ENABLE_N_I(oe_n), .PIXEL_OUT_BUS_O(pout),
    .PIXEL_OUT_OE_O(poe), .PIXEL_VALID_O(pvalid), .CTRL_SCLK_I(sclk),
    .CTRL_SERIAL_IN_I(ctrl_serial_in), .CTRL_LOAD_STROBE_I(ctrl_load_strobe), .CORR_SAMPLE_EN_O(cse),
    .GAIN_CODE_O(gain), .OFFSET_CODE_O(offs), .COEF_SEL_O(csel), .INPUT_MUX_O(imux));

  afe_host_model u_afe_host_model (.sdo_i(pout[7]), .sclk_o(sclk), .sdi_o(ctrl_serial_in),
    .sen_o(ctrl_load_strobe), .oe_n_o(oe_n));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One APB transfer: setup, then access until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Starts one pixel and collects its words; lat counts cycles to the first word.
  task automatic pix(input logic signed [14:0] c, input logic o, input logic [1:0] ch,
                     input int nw);
    @(posedge clk);
    code <= c;
    ovr <= o;
    chan <= ch;
    sync <= 1'b1;
    repeat (2) @(posedge clk);
    sync <= 1'b0;
    lat = 0;
    got = 32'h0;
    do begin
      @(posedge clk);
      lat++;
    end while (pvalid !== 1'b1);
    for (int i = 0; i < nw; i++) begin
      got = {got[23:0], pout};
      chk({31'h0, pvalid}, 32'h1, "valid run");
      @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask : pix

  // Expected words: offset, clip, invert, then the chosen packing.
  function automatic logic [31:0] exp_words(input logic signed [14:0] c, input logic o,
      input logic [1:0] ch, input logic [1:0] bl, input logic inv, input logic [1:0] f);
    logic signed [16:0] v;
    logic [13:0] d;
    logic ov;
    logic cc;
    v = c + ((bl == 2'h3) ? 17'sd0 : ((bl == 2'h2) ? 17'sd16383 : 17'sd8191));
    ov = o | (v < 0) | (v > 17'sd16383);
    d = (v < 0) ? 14'h0000 : ((v > 17'sd16383) ? MAX_CODE : v[13:0]);
    if (inv) d = MAX_CODE - d;
    cc = (ch == CH_GREEN);
    case (f)
      2'h2: return {16'h0, d[13:7], cc, d[6:0], ov};
      2'h3: return {d[13:10], 4'h0, d[9:6], 4'h0, d[5:2], 4'h0, d[1:0], cc, ov, 4'h0};
      default: return {16'h0, d[13:6], d[5:0], cc, ov};
    endcase
  endfunction : exp_words

  // Prints the counts and the verdict, then stops the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Watchdog well beyond the expected run of about 40 us.
  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat, 32'h02, "setup1 reset");
    chk({31'h0, cse}, 32'h1, "cds out");
    apb(1'b0, 12'h0fc, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped");
    chk({31'h0, poe}, 32'h1, "pins enabled");
    apb(1'b0, 12'h100, 32'h0);
    chk(rdat, 32'h01, "status idle");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      u_afe_host_model.send({ADDR_GAIN_R + 6'(i), 8'(17 * (i + 1))});
      u_afe_host_model.send({ADDR_OFF_R + 6'(i), 8'(160 + i)});
    end
    chk({8'h0, gain}, {8'h0, 24'h332211}, "gains");
    chk({8'h0, offs}, {8'h0, 24'ha2a1a0}, "offsets");
    apb(1'b0, 12'h0a0, 32'h0);
    chk(rdat, 32'h11, "gain red apb");
    u_afe_host_model.send({ADDR_GAIN_R | 6'h10, 8'hff});
    u_afe_host_model.send({ADDR_GAIN_R + 6'h1, 8'h5a});
    chk({24'h0, u_afe_host_model.rd_bits}, 32'h11, "read-back");
    chk({8'h0, gain}, {8'h0, 24'h335a11}, "gain after read");
    $display("test serial done");
    for (int k = 0; k < 16; k++) begin
      kk = 4'(k);
      apb(1'b1, 12'h004, {25'h0, kk[3:2], kk[1:0], kk[2], 1'b1, 1'b0});
      pix(codes[kk[1:0]], kk[2], (kk[1:0] == 2'h3) ? 2'h1 : kk[1:0], (kk[3:2] == 2'h3) ? 4 : 2);
      chk(got, exp_words(codes[kk[1:0]], kk[2], (kk[1:0] == 2'h3) ? 2'h1 : kk[1:0],
          kk[1:0], kk[2], kk[3:2]), "pixel words");
    end
    $display("test formats done");
    apb(1'b1, 12'h004, 32'h02);
    u_afe_host_model.send({ADDR_SETUP2, 8'h00});
    pix(15'sd0, 1'b0, 2'h0, 2);
    chk(got, exp_words(15'sd0, 1'b0, 2'h0, 2'h0, 1'b0, 2'h0), "mid scale");
    l0 = lat;
    u_afe_host_model.send({ADDR_SETUP2, 8'h03});
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat, 32'h03, "setup2 apb");
    pix(15'sd100, 1'b0, 2'h0, 2);
    chk(32'(lat - l0), 32'd3, "latency step");
    chk(got, exp_words(15'sd100, 1'b0, 2'h0, 2'h0, 1'b0, 2'h0), "late words");
    $display("test latency done");
    u_afe_host_model.send({ADDR_SETUP2, 8'h44});
    chk({30'h0, csel}, 32'h0, "cycle start");
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      cyc <= 1'b1;
      repeat (2) @(posedge clk);
      cyc <= 1'b0;
      repeat (6) @(posedge clk);
      chk({30'h0, csel}, 32'(i % 3), "cycle coef");
      chk({30'h0, imux}, 32'(i % 3), "cycle mux");
    end
    u_afe_host_model.send({ADDR_SETUP2, 8'h60});
    chk({30'h0, csel}, 32'h2, "select coef");
    chk({30'h0, imux}, 32'h2, "select mux");
    $display("test colour done");
    print_verdict();
  end
endmodule : tb_afe_output_format_and_serial_ctrl
